// File: core/crc_comparator_reference_control.sv
// Comparator, programmable reference and temperature sensor control.
// Assumes analog comparator results and port logic are synchronous to clock.
//
// Our own choice: the Avalon-MM slave port.
`timescale 1ns/100ps

// Summary of operation
// - Temperature sensor powered while its disable clear
// - Temperature sensor routed to converter channel seven
// - Each comparator negative input from own reference
// - After reset both positives take first input
// - Comparator B pin enable selects second input
// - Result bits read-only at positions two, six
// - Flag sets when result XOR invert is one
// - Interrupt needs local, peripheral and global enables
// - Request is level sensitive, held while true
// - Pin enable drives comparator result, overriding direction
// - Pin enable also connects matching reference pin
// - Comparator disable bit powers down both comparators and references
// - Reference select: coarse 7:3, fine 2:0
// - Coarse code selects one of 32 taps
// - Coarse step 5 mV middle, 50 mV outer
// - Coarse code decodes in sign-magnitude order
// - Fine code n gives (n+1)/8 of step
// - References routed to converter channels 8, 9
// - Reference pins live while pin enable set
// - Level shifters on while shift disable clear
module crc_comparator_reference_control
    import crc_pkg::*;
(
    input  wire logic         clock,
    input  wire logic         rstn,
    input  wire crc_avs_req_s avs_req,
    output logic              avs_waitrequest,
    output logic [31:0]       avs_readdata,
    input  wire logic         comp_a_raw,
    input  wire logic         comp_b_raw,
    input  wire logic [3:0]   adc_channel,
    input  wire logic         port_comp_a_o,
    input  wire logic         port_comp_a_oe,
    input  wire logic         port_comp_b_o,
    input  wire logic         port_comp_b_oe,
    output crc_analog_s       analog_ctl,
    output crc_ref_s          ref_a_set,
    output crc_ref_s          ref_b_set,
    output crc_pins_s         pins,
    output logic              comp_irq_req
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [7:0]  ref_a;
        logic [7:0]  ref_b;
        logic [7:0]  cmp;
        logic [7:0]  sleep;
        logic        flag;
        logic        irq_en;
        logic [1:0]  irqc;
        logic        ack;
        logic [31:0] rdata;
    } crc_state_s;

    crc_state_s st_q;
    crc_state_s st_d;

    // Sign-magnitude coarse code to ladder tap, 0 is the bottom tap
    function automatic crc_ref_s decode_ref(input logic [7:0] sel);
        crc_ref_s   r;
        logic [4:0] c;
        c = sel[7:3];
        r.fine_eighths = {1'b0, sel[2:0]} + 4'h1;
        if (c[4]) begin
            r.tap = 5'h0F - {1'b0, c[3:0]};
        end else begin
            r.tap = 5'h10 + {1'b0, c[3:0]};
        end
        if (r.tap >= 5'h1A) begin
            r.range = CRC_RANGE_UPPER;
        end else if (r.tap >= 5'h06) begin
            r.range = CRC_RANGE_MIDDLE;
        end else begin
            r.range = CRC_RANGE_LOWER;
        end
        if (r.range == CRC_RANGE_MIDDLE) begin
            r.step_mv = 6'(CRC_STEP_MID_MV);
        end else begin
            r.step_mv = 6'(CRC_STEP_OUTER_MV);
        end
        return r;
    endfunction

    // ****************************************************************
    // Comparator results and interrupt condition
    // ****************************************************************
    logic comp_on;
    logic res_a;
    logic res_b;
    logic cond;
    logic [7:0] cmp_view;
    logic sel_hit;
    logic [7:0] idx;

    // Powered-down comparators read as low so stale analog levels cannot fire
    assign comp_on = ~st_q.sleep[CRC_SLP_COMP];
    assign res_a = comp_on & comp_a_raw;
    assign res_b = comp_on & comp_b_raw;
    assign cond = (res_a ^ st_q.cmp[CRC_CMP_INV_A])
                | (res_b ^ st_q.cmp[CRC_CMP_INV_B]);

    always_comb begin
        cmp_view = st_q.cmp & CRC_CMP_WMASK;
        cmp_view[CRC_CMP_RES_A] = res_a;
        cmp_view[CRC_CMP_RES_B] = res_b;
    end

    assign idx = avs_req.address[9:2];
    assign sel_hit = (avs_req.read | avs_req.write) & ~st_q.ack;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        st_d = st_q;
        st_d.ack = sel_hit;
        st_d.rdata = 32'h0;
        // Writes land on the answer edge, where waitrequest is low
        if (avs_req.write && st_q.ack) begin
            unique case (idx)
                CRC_IDX_REF_A: st_d.ref_a = avs_req.writedata[7:0];
                CRC_IDX_REF_B: st_d.ref_b = avs_req.writedata[7:0];
                CRC_IDX_CMP:   st_d.cmp = avs_req.writedata[7:0] & CRC_CMP_WMASK;
                CRC_IDX_SLEEP: st_d.sleep = avs_req.writedata[7:0];
                CRC_IDX_PIRQ:  st_d.flag = avs_req.writedata[CRC_PIR_COMP];
                CRC_IDX_PIEN:  st_d.irq_en = avs_req.writedata[CRC_PIE_COMP];
                CRC_IDX_IRQC:  st_d.irqc = avs_req.writedata[7:6];
                default: ;
            endcase
        end
        if (sel_hit && avs_req.read) begin
            unique case (idx)
                CRC_IDX_REF_A: st_d.rdata = {24'h0, st_q.ref_a};
                CRC_IDX_REF_B: st_d.rdata = {24'h0, st_q.ref_b};
                CRC_IDX_CMP:   st_d.rdata = {24'h0, cmp_view};
                CRC_IDX_SLEEP: st_d.rdata = {24'h0, st_q.sleep};
                CRC_IDX_PIRQ:  st_d.rdata = {24'h0, st_q.flag, 7'h0};
                CRC_IDX_PIEN:  st_d.rdata = {24'h0, st_q.irq_en, 7'h0};
                CRC_IDX_IRQC:  st_d.rdata = {24'h0, st_q.irqc, 6'h0};
                default:       st_d.rdata = 32'h0;
            endcase
        end
        // Set beats a same-cycle software clear
        if (cond) begin
            st_d.flag = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // One wait state on every access keeps read data registered
    assign avs_waitrequest = (avs_req.read | avs_req.write) & ~st_q.ack;
    assign avs_readdata = st_q.rdata;

    // Level request; drops when software clears the flag while the condition is false, or clears an enable
    assign comp_irq_req = st_q.flag & st_q.irq_en
                        & st_q.irqc[1] & st_q.irqc[0];

    always_comb begin
        analog_ctl.temp_sensor_on = ~st_q.sleep[CRC_SLP_TEMP];
        analog_ctl.comp_ref_on = comp_on;
        analog_ctl.level_shift_on = ~st_q.sleep[CRC_SLP_SHIFT];
        // Comparator A always takes the first shifted input
        analog_ctl.comp_b_pos_second = st_q.cmp[CRC_CMP_PIN_B];
        analog_ctl.adc_temp_sel = (adc_channel == CRC_ADC_CH_TEMP);
        analog_ctl.adc_ref_a_sel = (adc_channel == CRC_ADC_CH_REF_A);
        analog_ctl.adc_ref_b_sel = (adc_channel == CRC_ADC_CH_REF_B);
    end

    // Each ladder code feeds only its own comparator's negative input
    assign ref_a_set = decode_ref(st_q.ref_a);
    assign ref_b_set = decode_ref(st_q.ref_b);

    always_comb begin
        if (st_q.cmp[CRC_CMP_PIN_A]) begin
            pins.comp_a_pin_o = res_a;
            pins.comp_a_pin_oe = 1'b1;
        end else begin
            pins.comp_a_pin_o = port_comp_a_o;
            pins.comp_a_pin_oe = port_comp_a_oe;
        end
        if (st_q.cmp[CRC_CMP_PIN_B]) begin
            pins.comp_b_pin_o = res_b;
            pins.comp_b_pin_oe = 1'b1;
        end else begin
            pins.comp_b_pin_o = port_comp_b_o;
            pins.comp_b_pin_oe = port_comp_b_oe;
        end
        pins.ref_a_pin_connect = st_q.cmp[CRC_CMP_PIN_A];
        pins.ref_b_pin_connect = st_q.cmp[CRC_CMP_PIN_B];
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    a_flag_sets: assert property (cond |=> st_q.flag)
        else $error("flag not set after condition");
    a_flag_holds: assert property (cond ##1 cond |-> st_q.flag [*1] ##1 st_q.flag)
        else $error("flag dropped while condition held");
    a_irq_gate: assert property (comp_irq_req |-> st_q.irq_en && st_q.irqc == 2'h3)
        else $error("request without all enables");
    a_irq_level: assert property (
        st_q.flag && st_q.irq_en && st_q.irqc == 2'h3 |-> comp_irq_req)
        else $error("request missing while enabled flag set");
    a_result_read: assert property (
        sel_hit && avs_req.read && idx == CRC_IDX_CMP
        |=> avs_readdata[CRC_CMP_RES_A] == $past(res_a))
        else $error("result A not returned");
    a_result_ro: assert property (
        avs_req.write && st_q.ack && idx == CRC_IDX_CMP
        |=> !st_q.cmp[CRC_CMP_RES_A] && !st_q.cmp[CRC_CMP_RES_B])
        else $error("result bit stored by write");
    a_pin_override: assert property (
        st_q.cmp[CRC_CMP_PIN_B] |-> pins.comp_b_pin_oe && pins.comp_b_pin_o == res_b)
        else $error("comparator B pin not driven");
    a_off_quiet: assert property (
        st_q.sleep[CRC_SLP_COMP] |-> !res_a && !res_b && !analog_ctl.comp_ref_on)
        else $error("comparators active while disabled");
    a_wait_one: assert property (sel_hit |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("access not answered after one wait state");
    a_reset_window: assert property ($rose(rstn) |-> !analog_ctl.comp_b_pos_second)
        else $error("window mode not selected after reset");

    // ****************************************************************
    // Assertions on the interrupt path and result B read
    // ****************************************************************
    a_flag_source: assert property (
        $rose(st_q.flag) |-> $past(cond)
        || ($past(avs_req.write) && $past(st_q.ack) && $past(idx) == CRC_IDX_PIRQ))
        else $error("flag rose without cause");
    a_irq_global: assert property (
        !st_q.irqc[1] |-> !comp_irq_req)
        else $error("request without global enable");
    a_irq_periph: assert property (
        !st_q.irqc[0] |-> !comp_irq_req)
        else $error("request without peripheral enable");
    a_irq_local: assert property (
        !st_q.irq_en |-> !comp_irq_req)
        else $error("request without local enable");
    a_irq_stays: assert property (
        comp_irq_req && !(avs_req.write && st_q.ack) |=> comp_irq_req)
        else $error("request fell without software action");
    a_clear_lost: assert property (
        cond && avs_req.write && st_q.ack && idx == CRC_IDX_PIRQ
        |=> st_q.flag)
        else $error("clear beat a live condition");
    a_clear_takes: assert property (
        !cond && avs_req.write && st_q.ack && idx == CRC_IDX_PIRQ
        && !avs_req.writedata[CRC_PIR_COMP] |=> !st_q.flag)
        else $error("flag kept after clear");
    a_result_b_read: assert property (
        sel_hit && avs_req.read && idx == CRC_IDX_CMP
        |=> avs_readdata[CRC_CMP_RES_B] == $past(res_b))
        else $error("result B not returned");

    // ****************************************************************
    // Assertions on power, routing and pins
    // ****************************************************************
    a_temp_power: assert property (
        analog_ctl.temp_sensor_on == !st_q.sleep[CRC_SLP_TEMP])
        else $error("temperature sensor power wrong");
    a_temp_channel: assert property (
        analog_ctl.adc_temp_sel == (adc_channel == CRC_ADC_CH_TEMP))
        else $error("temperature channel select wrong");
    a_ref_a_own: assert property (
        avs_req.write && st_q.ack && idx == CRC_IDX_REF_A |=> $stable(ref_b_set))
        else $error("reference A write moved reference B");
    a_ref_b_own: assert property (
        avs_req.write && st_q.ack && idx == CRC_IDX_REF_B |=> $stable(ref_a_set))
        else $error("reference B write moved reference A");
    a_window_mode: assert property (
        !st_q.cmp[CRC_CMP_PIN_B] |-> !analog_ctl.comp_b_pos_second)
        else $error("window mode lost");
    a_split_mode: assert property (
        st_q.cmp[CRC_CMP_PIN_B] |-> analog_ctl.comp_b_pos_second)
        else $error("second input not selected");
    a_pin_a_drive: assert property (
        st_q.cmp[CRC_CMP_PIN_A]
        |-> pins.comp_a_pin_oe && pins.comp_a_pin_o == res_a)
        else $error("comparator A pin not driven");
    a_pin_a_port: assert property (
        !st_q.cmp[CRC_CMP_PIN_A] |-> pins.comp_a_pin_o == port_comp_a_o
        && pins.comp_a_pin_oe == port_comp_a_oe)
        else $error("comparator A pin not released");
    a_pin_b_port: assert property (
        !st_q.cmp[CRC_CMP_PIN_B] |-> pins.comp_b_pin_o == port_comp_b_o
        && pins.comp_b_pin_oe == port_comp_b_oe)
        else $error("comparator B pin not released");
    a_ref_a_pin: assert property (
        pins.ref_a_pin_connect == st_q.cmp[CRC_CMP_PIN_A])
        else $error("reference A pin connection wrong");
    a_ref_pin_value: assert property (
        $rose(pins.ref_a_pin_connect) |-> $stable(ref_a_set))
        else $error("pin enable moved reference A");
    a_ref_b_pin: assert property (
        pins.ref_b_pin_connect == st_q.cmp[CRC_CMP_PIN_B])
        else $error("reference B pin connection wrong");
    a_comp_power: assert property (
        analog_ctl.comp_ref_on == !st_q.sleep[CRC_SLP_COMP])
        else $error("comparator power wrong");
    a_ref_channels: assert property (
        analog_ctl.adc_ref_a_sel == (adc_channel == CRC_ADC_CH_REF_A)
        && analog_ctl.adc_ref_b_sel == (adc_channel == CRC_ADC_CH_REF_B))
        else $error("reference channel select wrong");
    a_shift_power: assert property (
        analog_ctl.level_shift_on == !st_q.sleep[CRC_SLP_SHIFT])
        else $error("level shift power wrong");

    // ****************************************************************
    // Assertions on reference decode
    // ****************************************************************
    a_coarse_only: assert property (
        $stable(st_q.ref_a[7:3]) |-> $stable(ref_a_set.tap))
        else $error("fine bits moved the tap");
    a_upper_edge: assert property (
        st_q.ref_a[7:3] == 5'h0A |-> ref_a_set.range == CRC_RANGE_UPPER)
        else $error("upper range start wrong");
    a_lower_edge: assert property (
        st_q.ref_a[7:3] == 5'h1A |-> ref_a_set.range == CRC_RANGE_LOWER)
        else $error("lower range start wrong");
    a_mid_edges: assert property (
        st_q.ref_a[7:3] == 5'h09 || st_q.ref_a[7:3] == 5'h19
        |-> ref_a_set.range == CRC_RANGE_MIDDLE)
        else $error("middle range ends wrong");
    a_mid_step: assert property (
        ref_a_set.range == CRC_RANGE_MIDDLE |-> ref_a_set.step_mv == 6'h05)
        else $error("middle step wrong");
    a_outer_step: assert property (
        ref_b_set.range != CRC_RANGE_MIDDLE |-> ref_b_set.step_mv == 6'h32)
        else $error("outer step wrong");
    a_tap_top: assert property (
        st_q.ref_a[7:3] == 5'h0F |-> ref_a_set.tap == 5'h1F)
        else $error("top tap wrong");
    a_tap_bottom: assert property (
        st_q.ref_b[7:3] == 5'h1F |-> ref_b_set.tap == 5'h00)
        else $error("bottom tap wrong");
    a_tap_centre: assert property (
        st_q.ref_a[7:3] == 5'h00 |-> ref_a_set.tap == 5'h10)
        else $error("centre tap wrong");
    a_tap_below: assert property (
        st_q.ref_a[7:3] == 5'h10 |-> ref_a_set.tap == 5'h0F)
        else $error("tap below centre wrong");
    a_fine_least: assert property (
        st_q.ref_a[2:0] == 3'h0 |-> ref_a_set.fine_eighths == 4'h1)
        else $error("smallest fraction wrong");
    a_fine_full: assert property (
        st_q.ref_b[2:0] == 3'h7 |-> ref_b_set.fine_eighths == 4'h8)
        else $error("full fraction wrong");

    c_irq_seen: cover property (comp_irq_req);
    c_flag_relatch: cover property (st_q.flag ##1 cond ##1 st_q.flag);
    c_split_mode: cover property (analog_ctl.comp_b_pos_second && pins.ref_b_pin_connect);
    c_read_cmp: cover property (sel_hit && avs_req.read && idx == CRC_IDX_CMP);
    c_upper_range: cover property (ref_a_set.range == CRC_RANGE_UPPER);

endmodule

// File: core/crc_pkg.sv
// Constants and types for the comparator and reference control block.
// Assumes a 32-bit Avalon-MM slave with byte addresses and word registers.
package crc_pkg;

    // ****************************************************************
    // Register indices, byte address is four times the index
    // ****************************************************************
    localparam logic [7:0] CRC_IDX_REF_A  = 8'h9B;
    localparam logic [7:0] CRC_IDX_REF_B  = 8'h9C;
    localparam logic [7:0] CRC_IDX_CMP    = 8'h9D;
    localparam logic [7:0] CRC_IDX_SLEEP  = 8'hA0;
    localparam logic [7:0] CRC_IDX_PIRQ   = 8'hA1;
    localparam logic [7:0] CRC_IDX_PIEN   = 8'hA2;
    localparam logic [7:0] CRC_IDX_IRQC   = 8'hA3;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int CRC_CMP_INV_A   = 0;
    localparam int CRC_CMP_PIN_A   = 1;
    localparam int CRC_CMP_RES_A   = 2;
    localparam int CRC_CMP_INV_B   = 4;
    localparam int CRC_CMP_PIN_B   = 5;
    localparam int CRC_CMP_RES_B   = 6;
    localparam int CRC_SLP_TEMP    = 1;
    localparam int CRC_SLP_COMP    = 2;
    localparam int CRC_SLP_SHIFT   = 4;
    localparam int CRC_PIR_COMP    = 7;
    localparam int CRC_PIE_COMP    = 7;
    localparam int CRC_IRQC_GLOBAL = 7;
    localparam int CRC_IRQC_PERIPH = 6;
    localparam int CRC_REF_FINE_W  = 3;
    localparam int CRC_REF_COARSE_W = 5;

    // Writable bits of the comparator control word, result bits excluded
    localparam logic [7:0] CRC_CMP_WMASK  = 8'h33;
    localparam logic [7:0] CRC_RESET_BYTE = 8'h00;

    // ****************************************************************
    // Analog routing and ladder figures
    // ****************************************************************
    localparam logic [3:0] CRC_ADC_CH_TEMP  = 4'h7;
    localparam logic [3:0] CRC_ADC_CH_REF_A = 4'h8;
    localparam logic [3:0] CRC_ADC_CH_REF_B = 4'h9;
    localparam int CRC_LADDER_TAPS   = 32;
    localparam int CRC_STEP_MID_MV   = 5;
    localparam int CRC_STEP_OUTER_MV = 50;

    typedef enum logic [1:0] {CRC_RANGE_LOWER, CRC_RANGE_MIDDLE, CRC_RANGE_UPPER} crc_range_e;

    // Decoded reference setting handed to the analog ladder
    typedef struct packed {
        logic [4:0] tap;
        logic [3:0] fine_eighths;
        crc_range_e range;
        logic [5:0] step_mv;
    } crc_ref_s;

    // Avalon-MM slave request
    typedef struct packed {
        logic [9:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
    } crc_avs_req_s;

    // Analog power and routing controls
    typedef struct packed {
        logic temp_sensor_on;
        logic comp_ref_on;
        logic level_shift_on;
        logic comp_b_pos_second;
        logic adc_temp_sel;
        logic adc_ref_a_sel;
        logic adc_ref_b_sel;
    } crc_analog_s;

    // Pin drive
    typedef struct packed {
        logic comp_a_pin_o;
        logic comp_a_pin_oe;
        logic comp_b_pin_o;
        logic comp_b_pin_oe;
        logic ref_a_pin_connect;
        logic ref_b_pin_connect;
    } crc_pins_s;

endpackage

// File: tb/crc_irq_sink.sv
// Processor side model: watches the comparator interrupt request.
// Assumes the request is a level synchronous to clock.
`timescale 1ns/100ps
module crc_irq_sink (
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic        comp_irq_req,
    output logic      [15:0] high_cycles_q
);
    // Counts every cycle the request stands, so a request that drops early shows up short
    always_ff @(posedge clock) begin
        if (!rstn) begin
            high_cycles_q <= 16'h0000;
        end else if (comp_irq_req) begin
            high_cycles_q <= high_cycles_q + 16'h0001;
        end
    end
endmodule

// File: tb/tb_comparator_reference_control.sv
// Self-checking bench for the comparator and reference control block.
// Assumes a 10 MHz clock and the one-wait-state Avalon slave of the core.
`timescale 1ns/100ps
module tb_comparator_reference_control;
    import crc_pkg::*;
    logic         clock;
    logic         rstn;
    crc_avs_req_s req;
    logic         avs_waitrequest;
    logic [31:0]  avs_readdata;
    logic         raw_a;
    logic         raw_b;
    logic [3:0]   adc_channel;
    logic [3:0]   port_drv;
    crc_analog_s  analog_ctl;
    crc_ref_s     ref_a_set;
    crc_ref_s     ref_b_set;
    crc_pins_s    pins;
    logic         comp_irq_req;
    logic [15:0]  high_cycles;
    logic [31:0]  rd;
    int           fails;
    int           num_checks;
    int           c0;
    logic [7:0]   regs [7] = '{CRC_IDX_REF_A, CRC_IDX_REF_B, CRC_IDX_CMP, CRC_IDX_SLEEP,
                               CRC_IDX_PIRQ, CRC_IDX_PIEN, CRC_IDX_IRQC};
    logic [7:0]   codes [8] = '{8'h7F, 8'hF8, 8'h03, 8'h85, 8'h52, 8'h4E, 8'hD1, 8'hC8};
    logic [7:0]   slp [4] = '{8'h02, 8'h04, 8'h10, 8'h00};

    crc_comparator_reference_control dut (
        .clock(clock), .rstn(rstn), .avs_req(req), .avs_waitrequest(avs_waitrequest),
        .avs_readdata(avs_readdata), .comp_a_raw(raw_a), .comp_b_raw(raw_b),
        .adc_channel(adc_channel), .port_comp_a_o(port_drv[3]), .port_comp_a_oe(port_drv[2]),
        .port_comp_b_o(port_drv[1]), .port_comp_b_oe(port_drv[0]), .analog_ctl(analog_ctl),
        .ref_a_set(ref_a_set), .ref_b_set(ref_b_set), .pins(pins), .comp_irq_req(comp_irq_req)
    );
    crc_irq_sink cpu (
        .clock(clock), .rstn(rstn), .comp_irq_req(comp_irq_req), .high_cycles_q(high_cycles)
    );

    always #50 clock = ~clock;

    // ****************************************************************
    // Bus and compare tasks
    // ****************************************************************
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Entered just after a rising edge; holds the request until waitrequest is seen low
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        req <= '{address: {idx, 2'b00}, read: !wr, write: wr, writedata: {24'h000000, wd}};
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0);
        chk("bus wait states", 32'h2, 32'(n));
        rd = avs_readdata;
        req <= '0;
        // Idle edge so the next request never lands in the release time step
        @(posedge clock);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
        bus(1'b1, idx, wd);
    endtask

    task automatic rdx(input logic [7:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        chk($sformatf("register %h", idx), {24'h000000, exp}, rd);
    endtask

    function automatic crc_ref_s exp_ref(input logic [7:0] v);
        crc_ref_s r;
        r.tap = v[7] ? 5'h1F - v[7:3] : 5'h10 + v[7:3];
        r.fine_eighths = {1'b0, v[2:0]} + 4'h1;
        r.range = (r.tap < 5'h06) ? CRC_RANGE_LOWER
                : (r.tap > 5'h19) ? CRC_RANGE_UPPER : CRC_RANGE_MIDDLE;
        r.step_mv = (r.range == CRC_RANGE_MIDDLE) ? 6'h05 : 6'h32;
        return r;
    endfunction

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ****************************************************************
    // Tests
    // ****************************************************************
    initial begin
        fails = 0;
        num_checks = 0;
        clock = 1'b0;
        rstn = 1'b0;
        req = '0;
        raw_a = 1'b0;
        raw_b = 1'b0;
        adc_channel = 4'h0;
        port_drv = 4'h9;
        repeat (16) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        foreach (regs[i]) rdx(regs[i], 8'h00);
        chk("power after reset", 32'hE, {28'h0, analog_ctl[6:3]});
        $display("test reset done");
        foreach (codes[i]) begin
            wr(CRC_IDX_REF_A, codes[i]);
            wr(CRC_IDX_REF_B, ~codes[i]);
            chk("ref a", {15'h0, exp_ref(codes[i])}, {15'h0, ref_a_set});
            chk("ref b", {15'h0, exp_ref(~codes[i])}, {15'h0, ref_b_set});
            rdx(CRC_IDX_REF_A, codes[i]);
        end
        $display("test reference decode done");
        raw_a <= 1'b1;
        @(posedge clock);
        rdx(CRC_IDX_PIRQ, 8'h80);
        rdx(CRC_IDX_CMP, 8'h04);
        chk("irq masked", 32'h0, {31'h0, comp_irq_req});
        wr(CRC_IDX_CMP, 8'hFF);
        rdx(CRC_IDX_CMP, 8'h37);
        chk("pins enabled", 32'h37, {26'h0, pins});
        chk("b second input", 32'h1, {31'h0, analog_ctl.comp_b_pos_second});
        wr(CRC_IDX_PIEN, 8'h80);
        wr(CRC_IDX_IRQC, 8'h40);
        chk("irq no global", 32'h0, {31'h0, comp_irq_req});
        wr(CRC_IDX_IRQC, 8'hC0);
        rdx(CRC_IDX_IRQC, 8'hC0);
        chk("irq on", 32'h1, {31'h0, comp_irq_req});
        c0 = high_cycles;
        repeat (4) @(posedge clock);
        chk("irq level", 32'h4, 32'(high_cycles) - 32'(c0));
        wr(CRC_IDX_PIRQ, 8'h00);
        rdx(CRC_IDX_PIRQ, 8'h80);
        wr(CRC_IDX_CMP, 8'h01);
        wr(CRC_IDX_PIRQ, 8'h00);
        rdx(CRC_IDX_PIRQ, 8'h00);
        chk("irq cleared", 32'h0, {31'h0, comp_irq_req});
        chk("pins to port", 32'h24, {26'h0, pins});
        raw_b <= 1'b1;
        @(posedge clock);
        rdx(CRC_IDX_PIRQ, 8'h80);
        rdx(CRC_IDX_CMP, 8'h45);
        wr(CRC_IDX_CMP, 8'h20);
        chk("ref b pin", 32'h1, {31'h0, pins.ref_b_pin_connect});
        $display("test comparator and interrupt done");
        foreach (slp[i]) begin
            wr(CRC_IDX_SLEEP, slp[i]);
            rdx(CRC_IDX_SLEEP, slp[i]);
            rdx(CRC_IDX_CMP, slp[i][2] ? 8'h20 : 8'h64);
            chk("power", {29'h0, ~slp[i][1], ~slp[i][2], ~slp[i][4]},
                {29'h0, analog_ctl[6:4]});
        end
        for (int ch = 0; ch < 16; ch++) begin
            adc_channel <= 4'(ch);
            @(posedge clock);
            chk("adc select", {29'h0, ch == 7, ch == 8, ch == 9},
                {29'h0, analog_ctl[2:0]});
        end
        wr(8'h9E, 8'hFF);
        rdx(8'h9E, 8'h00);
        $display("test power and routing done");
        tally_and_finish();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clock);
        fails++;
        tally_and_finish();
    end
endmodule
